// File: rtl/bss_map.svh
// constants of the buck switching sequencer: timing counts and mode encodings
`ifndef BSS_MAP_SVH
`define BSS_MAP_SVH
`define BSS_CLK_MHZ          125
`define BSS_TOFF_MIN_NS      310
`define BSS_TOFF_MIN_CYC     ((`BSS_TOFF_MIN_NS * `BSS_CLK_MHZ) / 1000)
`define BSS_SS_INT_NS        1045000
`define BSS_SS_INT_CYC       ((`BSS_SS_INT_NS / 1000) * `BSS_CLK_MHZ)
`define BSS_MODE_WAIT_US     400
`define BSS_MODE_WAIT_CYC    (`BSS_MODE_WAIT_US * `BSS_CLK_MHZ)
`define BSS_MODE_FIN_US      55
`define BSS_MODE_FIN_CYC     (`BSS_MODE_FIN_US * `BSS_CLK_MHZ)
`define BSS_TON_400K_CYC     16'h0064
`define BSS_TON_800K_CYC     16'h0032
`define BSS_TON_1200K_CYC    16'h0021
`define BSS_PER_400K_CYC     16'h0138
`define BSS_PER_800K_CYC     16'h009C
`define BSS_PER_1200K_CYC    16'h0068
`define BSS_FLL_SPAN         16'h0010
`define BSS_MODE_MIN         4'h1
`define BSS_MODE_MAX         4'hC
`define BSS_DEAD_CYC         2'h1
`endif

// File: rtl/bss_pkg.sv
// types of the buck switching sequencer
package bss_pkg;
  typedef enum logic [1:0] {
    BSS_F400  = 2'b00,
    BSS_F800  = 2'b01,
    BSS_F1200 = 2'b10
  } bss_freq_t;
  typedef struct packed {
    logic      discontinuous_conduction;
    logic      current_limit_high;
    bss_freq_t freq;
  } bss_mode_t;
  typedef struct packed {
    logic feedback_below_ref;
    logic valley_over_limit;
    logic zero_cross;
    logic ss_above_feedback;
    logic ss_ext_done;
  } bss_cmp_t;
  typedef enum logic [2:0] {
    BSS_OFF     = 3'b000,
    BSS_MODE_RD = 3'b001,
    BSS_PREBIAS = 3'b010,
    BSS_RUN     = 3'b011
  } bss_seq_t;
  typedef enum logic [2:0] {
    BSS_IDLE  = 3'b000,
    BSS_DEAD1 = 3'b001,
    BSS_HS    = 3'b010,
    BSS_DEAD2 = 3'b011,
    BSS_LS    = 3'b100,
    BSS_ZOFF  = 3'b101
  } bss_sw_t;
endpackage

// File: rtl/bss_sequencer.sv
// control and sequencing logic of a synchronous step-down converter
`include "bss_map.svh"
module bss_sequencer #(
  parameter int unsigned SS_INT_CYC    = `BSS_SS_INT_CYC,
  parameter int unsigned MODE_WAIT_CYC = `BSS_MODE_WAIT_CYC,
  parameter int unsigned MODE_FIN_CYC  = `BSS_MODE_FIN_CYC
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             input_supply_ok,
  input  wire logic             supply_lockout,
  input  wire logic             enable_level,
  input  wire logic             enable_driven,
  input  wire logic             thermal_shutdown,
  input  wire bss_pkg::bss_cmp_t cmp,
  input  wire logic [3:0]       mode_index,
  input  wire logic             mode_valid,
  output logic                  high_side_switch,
  output logic                  low_side_switch,
  output logic                  ss_discharge,
  output logic                  ss_done,
  output logic                  mode_latched,
  output bss_pkg::bss_mode_t    mode_setting,
  output logic [15:0]           on_count
);
  localparam int unsigned TOFF_CYC = (`BSS_TOFF_MIN_CYC < 1) ? 1 : `BSS_TOFF_MIN_CYC;

  // ****************************************
  // input synchronisers
  // ****************************************
  localparam int NSYNC = 13;
  logic [NSYNC-1:0] raw_w;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  assign raw_w = {input_supply_ok, supply_lockout, enable_level, enable_driven, thermal_shutdown,
                  cmp, mode_valid, mode_index[3:2]};
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw_w;
      s2_q <= s1_q;
    end
  end
  logic [1:0] midx_lo_s1_q;
  logic [1:0] midx_lo_s2_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      midx_lo_s1_q <= 2'h0;
      midx_lo_s2_q <= 2'h0;
    end else begin
      midx_lo_s1_q <= mode_index[1:0];
      midx_lo_s2_q <= midx_lo_s1_q;
    end
  end

  wire sup_ok     = s2_q[12];
  wire lockout    = s2_q[11];
  wire en_lvl     = s2_q[10];
  wire en_drv     = s2_q[9];
  wire otp        = s2_q[8];
  wire fdbk_low   = s2_q[7];
  wire i_over     = s2_q[6];
  wire zc         = s2_q[5];
  wire ss_gt_fdbk = s2_q[4];
  wire ss_ext   = s2_q[3];
  wire m_valid  = s2_q[2];
  wire [3:0] midx = {s2_q[1:0], midx_lo_s2_q};

  wire en_on = en_lvl | ~en_drv;
  wire bias_ok = sup_ok & ~lockout;
  wire run_ok  = bias_ok & en_on & ~otp;

  // ****************************************
  // mode read and latch
  // ****************************************
  logic [31:0] mrd_cnt_q;
  logic        mrd_first_q;
  logic        mode_latched_q;
  bss_pkg::bss_mode_t mode_q;
  wire        midx_ok = (midx >= `BSS_MODE_MIN) && (midx <= `BSS_MODE_MAX);
  wire [3:0]  midx_m1 = midx - 4'h1;
  bss_pkg::bss_mode_t mode_dec_w;
  assign mode_dec_w = {(midx > 4'h6), ~midx[0],
                       (midx_m1 % 4'h6 < 4'h2) ? bss_pkg::BSS_F400 :
                       (midx_m1 % 4'h6 < 4'h4) ? bss_pkg::BSS_F800 : bss_pkg::BSS_F1200};
  wire mrd_first_hit = (mrd_cnt_q == MODE_WAIT_CYC);
  wire mrd_last_hit  = (mrd_cnt_q == MODE_WAIT_CYC + MODE_FIN_CYC);

  // cleared only by rst_n, the power cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mrd_cnt_q      <= 32'h0;
      mrd_first_q    <= 1'b0;
      mode_latched_q <= 1'b0;
      mode_q         <= '0;
    end else if (!mode_latched_q) begin
      if (!bias_ok) begin
        mrd_cnt_q   <= 32'h0;
        mrd_first_q <= 1'b0;
      end else begin
        mrd_cnt_q <= mrd_cnt_q + 32'h1;
        if (mrd_first_hit && m_valid && midx_ok) begin
          mrd_first_q <= 1'b1;
          mode_q      <= mode_dec_w;
        end
        if (mrd_last_hit && mrd_first_q && m_valid && midx_ok) begin
          mode_q         <= mode_dec_w;
          mode_latched_q <= 1'b1;
        end else if (mrd_last_hit) begin
          mrd_cnt_q <= 32'(MODE_WAIT_CYC + MODE_FIN_CYC);
        end
      end
    end
  end

  // ****************************************
  // startup sequence and soft-start
  // ****************************************
  bss_pkg::bss_seq_t seq_q;
  logic [31:0] ss_cnt_q;
  wire ss_int_done = (ss_cnt_q >= SS_INT_CYC);
  wire ss_done_w   = ss_int_done & ss_ext;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_q    <= bss_pkg::BSS_OFF;
      ss_cnt_q <= 32'h0;
    end else if (!run_ok) begin
      seq_q    <= bss_pkg::BSS_OFF;
      ss_cnt_q <= 32'h0;
    end else begin
      case (seq_q)
        bss_pkg::BSS_OFF:     seq_q <= bss_pkg::BSS_MODE_RD;
        bss_pkg::BSS_MODE_RD: if (mode_latched_q) seq_q <= bss_pkg::BSS_PREBIAS;
        // hold off until ramp above feedback
        bss_pkg::BSS_PREBIAS: begin
          if (!ss_int_done) ss_cnt_q <= ss_cnt_q + 32'h1;
          if (ss_gt_fdbk) seq_q <= bss_pkg::BSS_RUN;
        end
        bss_pkg::BSS_RUN:     if (!ss_int_done) ss_cnt_q <= ss_cnt_q + 32'h1;
        default:              seq_q <= bss_pkg::BSS_OFF;
      endcase
    end
  end
  wire sw_enable = run_ok && (seq_q == bss_pkg::BSS_RUN);

  // ****************************************
  // on-time and frequency-locked loop
  // ****************************************
  // nominal on count and period
  wire [15:0] ton_nom = (mode_q.freq == bss_pkg::BSS_F400) ? `BSS_TON_400K_CYC :
                        (mode_q.freq == bss_pkg::BSS_F800) ? `BSS_TON_800K_CYC : `BSS_TON_1200K_CYC;
  wire [15:0] per_nom = (mode_q.freq == bss_pkg::BSS_F400) ? `BSS_PER_400K_CYC :
                        (mode_q.freq == bss_pkg::BSS_F800) ? `BSS_PER_800K_CYC : `BSS_PER_1200K_CYC;
  logic [15:0] ton_q;
  logic [15:0] per_cnt_q;
  logic [15:0] tmr_q;
  bss_pkg::bss_sw_t sw_q;
  wire cycle_start = (sw_q == bss_pkg::BSS_DEAD2);
  // one step per switching cycle only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ton_q     <= `BSS_TON_400K_CYC;
      per_cnt_q <= 16'h0;
    end else if (!mode_latched_q) begin
      ton_q     <= ton_nom;
      per_cnt_q <= 16'h0;
    end else if (cycle_start) begin
      per_cnt_q <= 16'h0;
      if (per_cnt_q < per_nom && ton_q < ton_nom + `BSS_FLL_SPAN)
        ton_q <= ton_q + 16'h1;
      else if (per_cnt_q > per_nom && ton_q > ton_nom - `BSS_FLL_SPAN)
        ton_q <= ton_q - 16'h1;
    end else if (per_cnt_q != 16'hFFFF) begin
      per_cnt_q <= per_cnt_q + 16'h1;
    end
  end

  // ****************************************
  // switch state machine
  // ****************************************
  // on-interval trigger
  wire trig_ok = fdbk_low && !i_over && (tmr_q == 16'h0);
  bss_pkg::bss_sw_t sw_d;
  logic [15:0]      tmr_d;
  always_comb begin
    sw_d  = sw_q;
    tmr_d = (tmr_q != 16'h0) ? tmr_q - 16'h1 : 16'h0;
    if (!sw_enable) begin
      sw_d  = bss_pkg::BSS_IDLE;
      tmr_d = 16'h0;
    end else begin
      case (sw_q)
        bss_pkg::BSS_IDLE:  if (fdbk_low && !i_over) begin
          sw_d  = bss_pkg::BSS_DEAD1;
          tmr_d = 16'h0;
        end
        bss_pkg::BSS_DEAD1: begin
          sw_d  = bss_pkg::BSS_HS;
          tmr_d = ton_q - 16'h1;
        end
        bss_pkg::BSS_HS:    if (tmr_q == 16'h0) begin
          sw_d = bss_pkg::BSS_DEAD2;
        end
        bss_pkg::BSS_DEAD2: begin
          sw_d  = bss_pkg::BSS_LS;
          tmr_d = 16'(TOFF_CYC - 1);
        end
        bss_pkg::BSS_LS: begin
          if (mode_q.discontinuous_conduction && zc && !i_over && tmr_q == 16'h0)
            sw_d = bss_pkg::BSS_ZOFF;
          else if (trig_ok)
            sw_d = bss_pkg::BSS_DEAD1;
        end
        bss_pkg::BSS_ZOFF:  if (fdbk_low && !i_over) sw_d = bss_pkg::BSS_DEAD1;
        default:            sw_d = bss_pkg::BSS_IDLE;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_q  <= bss_pkg::BSS_IDLE;
      tmr_q <= 16'h0;
    end else begin
      sw_q  <= sw_d;
      tmr_q <= tmr_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  logic hs_q;
  logic ls_q;
  logic [15:0] hs_len_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_q     <= 1'b0;
      ls_q     <= 1'b0;
      hs_len_q <= 16'h0;
    end else begin
      hs_q     <= (sw_d == bss_pkg::BSS_HS);
      ls_q     <= (sw_d == bss_pkg::BSS_LS);
      hs_len_q <= hs_q ? hs_len_q + 16'h1 : 16'h0;
    end
  end
  assign high_side_switch = hs_q;
  assign low_side_switch  = ls_q;
  assign ss_discharge     = (seq_q == bss_pkg::BSS_OFF);
  assign ss_done          = sw_enable & ss_done_w;
  assign mode_latched     = mode_latched_q;
  assign mode_setting     = mode_q;
  assign on_count         = ton_q;

  // ****************************************
  // assertions
  // ****************************************
  property p_no_overlap;
    @(posedge core_clk) disable iff (!rst_n) !(hs_q && ls_q);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both switches on");
  property p_dead;
    @(posedge core_clk) disable iff (!rst_n) ($fell(hs_q) || $fell(ls_q)) |-> !(hs_q || ls_q);
  endproperty
  a_dead: assert property (p_dead) else $error("no dead time between switches");
  sequence s_hs_end;
    $fell(hs_q) && $past(sw_enable);
  endsequence
  property p_ontime;
    @(posedge core_clk) disable iff (!rst_n) s_hs_end |-> (hs_len_q == ton_q);
  endproperty
  a_ontime: assert property (p_ontime) else $error("on interval cut short");
  property p_hs_to_ls;
    @(posedge core_clk) disable iff (!rst_n) ($fell(hs_q) && sw_enable) |=> ls_q;
  endproperty
  a_hs_to_ls: assert property (p_hs_to_ls) else $error("low side not on after high side");
  property p_lockout_stop;
    @(posedge core_clk) disable iff (!rst_n) !bias_ok |-> ##2 (!hs_q && !ls_q);
  endproperty
  a_lockout_stop: assert property (p_lockout_stop) else $error("switching in lockout");
  property p_ss_dis;
    @(posedge core_clk) disable iff (!rst_n) !en_on |=> ss_discharge;
  endproperty
  a_ss_dis: assert property (p_ss_dis) else $error("soft-start not discharged");
  property p_mode_hold;
    @(posedge core_clk) disable iff (!rst_n) mode_latched_q |=> (mode_latched_q && $stable(mode_q));
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("latched mode changed");
  property p_no_ramp_early;
    @(posedge core_clk) disable iff (!rst_n) !mode_latched_q |-> !hs_q;
  endproperty
  a_no_ramp_early: assert property (p_no_ramp_early) else $error("switching before mode read");
  property p_ccm_zc;
    @(posedge core_clk) disable iff (!rst_n) !mode_q.discontinuous_conduction |-> sw_q != bss_pkg::BSS_ZOFF;
  endproperty
  a_ccm_zc: assert property (p_ccm_zc) else $error("zero-cross stop in continuous");
  property p_limit;
    @(posedge core_clk) disable iff (!rst_n) (ls_q && i_over && sw_enable) |=> !hs_q;
  endproperty
  a_limit: assert property (p_limit) else $error("on interval under current limit");
endmodule // bss_sequencer

// File: verif/bss_analog_model.sv
// far-side model: comparators, switch sensing and mode divider
module bss_analog_model (
  input  wire logic               core_clk,
  input  wire logic               high_side_switch,
  input  wire logic               low_side_switch,
  input  wire logic [3:0]         mode_sel,
  input  wire logic               feedback_hold,
  input  wire logic               light_load,
  input  wire logic               heavy_load,
  input  wire logic               prebias,
  input  wire logic               ext_done,
  output bss_pkg::bss_cmp_t       cmp,
  output logic [3:0]              mode_index,
  output logic                    mode_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // output ripple and inductor current
  // ****************
  int rip_q = 0;
  int ls_q  = 0;
  // feedback stays above reference for a while after each on pulse
  always @(negedge core_clk) begin
    rip_q <= high_side_switch ? 20 : ((rip_q > 0) ? rip_q - 1 : 0);
    ls_q  <= low_side_switch ? ls_q + 1 : 0;
  end
  assign cmp = '{~feedback_hold & (rip_q == 0), heavy_load & low_side_switch,
                 light_load & (ls_q >= 50), ~prebias, ext_done};
  assign mode_index = mode_sel;
  assign mode_valid = 1'b1;
endmodule // bss_analog_model

// File: verif/bss_sequencer_tb.sv
// self-checking bench of the buck switching sequencer
`include "bss_map.svh"
module bss_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SS    = 200;
  localparam int LATCH = 60;
  typedef struct packed {
    logic [3:0]         idx;
    bss_pkg::bss_mode_t m;
    logic [15:0]        on;
  } bss_row_t;
  logic               core_clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               input_supply_ok = 1'b0;
  logic               supply_lockout = 1'b1;
  logic               enable_level = 1'b1;
  logic               enable_driven = 1'b1;
  logic               thermal_shutdown = 1'b0;
  logic               feedback_hold = 1'b0;
  logic               light_load = 1'b0;
  logic               heavy_load = 1'b0;
  logic               prebias = 1'b0;
  logic               ext_done = 1'b1;
  logic [3:0]         mode_sel = 4'h1;
  logic [3:0]         mode_index;
  logic               mode_valid;
  bss_pkg::bss_cmp_t  cmp;
  logic               high_side_switch, low_side_switch, ss_discharge, ss_done, mode_latched;
  logic               hs_p, ls_p, early;
  bss_pkg::bss_mode_t mode_setting;
  logic [15:0]        on_count;
  int                 fail_count = 0;
  int                 checks = 0;
  int                 n;
  bss_row_t rows [12] = '{
    '{4'h1, '{1'b0, 1'b0, bss_pkg::BSS_F400},  `BSS_TON_400K_CYC},
    '{4'h2, '{1'b0, 1'b1, bss_pkg::BSS_F400},  `BSS_TON_400K_CYC},
    '{4'h3, '{1'b0, 1'b0, bss_pkg::BSS_F800},  `BSS_TON_800K_CYC},
    '{4'h4, '{1'b0, 1'b1, bss_pkg::BSS_F800},  `BSS_TON_800K_CYC},
    '{4'h5, '{1'b0, 1'b0, bss_pkg::BSS_F1200}, `BSS_TON_1200K_CYC},
    '{4'h6, '{1'b0, 1'b1, bss_pkg::BSS_F1200}, `BSS_TON_1200K_CYC},
    '{4'h7, '{1'b1, 1'b0, bss_pkg::BSS_F400},  `BSS_TON_400K_CYC},
    '{4'h8, '{1'b1, 1'b1, bss_pkg::BSS_F400},  `BSS_TON_400K_CYC},
    '{4'h9, '{1'b1, 1'b0, bss_pkg::BSS_F800},  `BSS_TON_800K_CYC},
    '{4'hA, '{1'b1, 1'b1, bss_pkg::BSS_F800},  `BSS_TON_800K_CYC},
    '{4'hB, '{1'b1, 1'b0, bss_pkg::BSS_F1200}, `BSS_TON_1200K_CYC},
    '{4'hC, '{1'b1, 1'b1, bss_pkg::BSS_F1200}, `BSS_TON_1200K_CYC}};

  bss_sequencer #(.SS_INT_CYC(SS), .MODE_WAIT_CYC(50), .MODE_FIN_CYC(10)) i_bss_sequencer (
    .core_clk, .rst_n, .input_supply_ok, .supply_lockout, .enable_level, .enable_driven,
    .thermal_shutdown, .cmp, .mode_index, .mode_valid, .high_side_switch, .low_side_switch,
    .ss_discharge, .ss_done, .mode_latched, .mode_setting, .on_count);
  bss_analog_model i_bss_analog_model (
    .core_clk, .high_side_switch, .low_side_switch, .mode_sel, .feedback_hold, .light_load,
    .heavy_load, .prebias, .ext_done, .cmp, .mode_index, .mode_valid);

  initial begin
    forever #4 core_clk = ~core_clk;
  end
  // ****************
  // helpers
  // ****************
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t bit got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chk_mode(input bss_pkg::bss_mode_t got, input bss_pkg::bss_mode_t exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t mode got %h exp %h", $time, got, exp);
    end
  endtask
  // loop trim plus one cycle of measuring slack
  task automatic chk_near(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if ((got + 16'h0011 >= exp && got <= exp + 16'h0011) !== 1'b1) begin
      fail_count++;
      $display("MISMATCH %0t count got %0d near %0d", $time, got, exp);
    end
  endtask
  task automatic wait_sw(input bit hi, input logic v, input int max, output int cnt);
    cnt = 0;
    while (((hi ? high_side_switch : low_side_switch) !== v) && cnt < max) begin
      @(negedge core_clk);
      cnt++;
    end
  endtask
  task automatic stay(input int cyc, input logic h, input logic l);
    logic ok;
    ok = 1'b1;
    repeat (cyc) begin
      @(negedge core_clk);
      if (high_side_switch !== h || low_side_switch !== l) ok = 1'b0;
    end
    chk_bit(ok, 1'b1);
  endtask
  task automatic power_up(input logic [3:0] m);
    rst_n = 1'b0;
    input_supply_ok = 1'b0;
    supply_lockout = 1'b1;
    mode_sel = m;
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    input_supply_ok = 1'b1;
    supply_lockout = 1'b0;
    n = 0;
    early = 1'b0;
    while (mode_latched !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
      if (high_side_switch !== 1'b0 || low_side_switch !== 1'b0) early = 1'b1;
    end
  endtask
  task automatic test_done;
    if (fail_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // never both on, one clock gap between
  always @(negedge core_clk) begin
    if ((high_side_switch & (low_side_switch | ls_p)) === 1'b1 || (low_side_switch & hs_p) === 1'b1) begin
      fail_count++;
      $display("MISMATCH %0t switches overlap", $time);
    end
    hs_p <= high_side_switch;
    ls_p <= low_side_switch;
  end
  // well over the expected length of the run
  initial begin
    #200000;
    fail_count++;
    test_done();
  end
  // ****************
  // tests
  // ****************
  initial begin
    repeat (16) @(negedge core_clk);
    chk_bit(high_side_switch | low_side_switch, 1'b0);
    chk_bit(ss_discharge, 1'b1);
    chk_bit(ss_done | mode_latched, 1'b0);
    chk_mode(mode_setting, '0);
    foreach (rows[i]) begin
      power_up(rows[i].idx);
      chk_bit(n >= LATCH && n <= LATCH + 8, 1'b1);
      chk_bit(early, 1'b0);
      chk_mode(mode_setting, rows[i].m);
      chk_near(on_count, rows[i].on);
    end
    // pre-biased start, then light load in discontinuous mode
    prebias = 1'b1;
    power_up(4'hB);
    stay(100, 1'b0, 1'b0);
    prebias = 1'b0;
    wait_sw(1'b1, 1'b1, 300, n);
    chk_bit(n < 300, 1'b1);
    wait_sw(1'b0, 1'b1, 200, n);
    feedback_hold = 1'b1;
    light_load = 1'b1;
    wait_sw(1'b0, 1'b0, 100, n);
    chk_bit(n >= 45 && n < 60, 1'b1);
    stay(60, 1'b0, 1'b0);
    feedback_hold = 1'b0;
    wait_sw(1'b1, 1'b1, 8, n);
    chk_bit(n < 8, 1'b1);
    light_load = 1'b0;
    // forced continuous: pulse shape, off time, soft-start end
    ext_done = 1'b0;
    power_up(4'h2);
    wait_sw(1'b1, 1'b1, 300, n);
    wait_sw(1'b1, 1'b0, 200, n);
    chk_near(n[15:0], `BSS_TON_400K_CYC);
    wait_sw(1'b0, 1'b1, 4, n);
    chk_bit(n < 4, 1'b1);
    wait_sw(1'b1, 1'b1, 200, n);
    chk_bit(n >= 39 && n < 60, 1'b1);
    repeat (SS) @(negedge core_clk);
    chk_bit(ss_done, 1'b0);
    ext_done = 1'b1;
    repeat (4) @(negedge core_clk);
    chk_bit(ss_done, 1'b1);
    wait_sw(1'b0, 1'b1, 200, n);
    feedback_hold = 1'b1;
    light_load = 1'b1;
    stay(100, 1'b0, 1'b1);
    light_load = 1'b0;
    heavy_load = 1'b1;
    feedback_hold = 1'b0;
    stay(100, 1'b0, 1'b1);
    heavy_load = 1'b0;
    wait_sw(1'b1, 1'b1, 8, n);
    chk_bit(n < 8, 1'b1);
    // stop and restart paths, with a different divider in place
    mode_sel = 4'h7;
    enable_level = 1'b0;
    repeat (6) @(negedge core_clk);
    chk_bit(high_side_switch | low_side_switch, 1'b0);
    chk_bit(ss_discharge, 1'b1);
    chk_mode(mode_setting, rows[1].m);
    enable_driven = 1'b0;
    wait_sw(1'b1, 1'b1, 400, n);
    chk_bit(n < 400, 1'b1);
    enable_driven = 1'b1;
    enable_level = 1'b1;
    for (int k = 0; k < 2; k++) begin
      supply_lockout = (k == 0);
      thermal_shutdown = (k == 1);
      repeat (6) @(negedge core_clk);
      chk_bit(high_side_switch | low_side_switch, 1'b0);
      supply_lockout = 1'b0;
      thermal_shutdown = 1'b0;
      wait_sw(1'b1, 1'b1, 500, n);
      chk_bit(n < 500, 1'b1);
      chk_mode(mode_setting, rows[1].m);
    end
    chk_near(on_count, `BSS_TON_400K_CYC);
    test_done();
  end
endmodule // bss_sequencer_tb
